// File: rtl/dbvf_cfg.svh
// Offsets, field positions, reset values and sizes of the memory-backed FIFO.
// Assumes it is included by bare name, possibly more than once.
`ifndef DBVF_CFG_SVH
`define DBVF_CFG_SVH
`define DBVF_ADDR_W          16
`define DBVF_OFF_PKT_LEN     16'h9104
`define DBVF_OFF_START       16'h9108
`define DBVF_OFF_END         16'h910C
`define DBVF_OFF_STATUS      16'h9110
`define DBVF_RST_PKT_LEN     32'h0000_1000
`define DBVF_RST_START       32'h0000_0000
`define DBVF_RST_END         32'h0001_0000
`define DBVF_DATA_W          32
`define DBVF_DEPTH           512
`define DBVF_PTR_W           9
`define DBVF_LVL_W           10
`define DBVF_SPACE_W         9
`define DBVF_SPACE_MAX       9'h1FF
`define DBVF_FULL_LVL        10'h200
`define DBVF_ROOM_LVL        10'h1FE
`define DBVF_WORD_BYTES      32'h0000_0004
`define DBVF_MEM_ADDR_W      30
`define DBVF_CMD_WRITE       3'h0
`define DBVF_CMD_READ        3'h1
`define DBVF_BURST_ONE       6'h00
`define DBVF_MASK_NONE       4'h0
`define DBVF_RESP_OKAY       2'h0
`define DBVF_RESP_SLVERR     2'h2
`define DBVF_STAT_WR_LSB     0
`define DBVF_STAT_RD_LSB     9
`define DBVF_STAT_EMPTY_BIT  18
`define DBVF_PKT_CNT_W       16
`endif

// File: rtl/dbvf_pkg.sv
// Types shared by the memory-backed FIFO modules.
// Assumes the constants header is on the include path.
`include "dbvf_cfg.svh"
package dbvf_pkg;
  typedef struct packed {
    logic [`DBVF_ADDR_W-1:0] awaddr;
    logic                    awvalid;
    logic [31:0]             wdata;
    logic [3:0]              wstrb;
    logic                    wvalid;
    logic                    bready;
    logic [`DBVF_ADDR_W-1:0] araddr;
    logic                    arvalid;
    logic                    rready;
  } dbvf_axil_in_type;
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } dbvf_axil_out_type;
  typedef struct packed {
    logic [`DBVF_DATA_W-1:0] data;
    logic                    sop;
    logic                    eop;
    logic                    valid;
  } dbvf_stream_type;
  typedef struct packed {
    logic                        cmd_en;
    logic [2:0]                  cmd_instr;
    logic [5:0]                  cmd_bl;
    logic [`DBVF_MEM_ADDR_W-1:0] cmd_addr;
    logic                        wr_en;
    logic [`DBVF_DATA_W-1:0]     wr_data;
    logic [3:0]                  wr_mask;
    logic                        rd_en;
  } dbvf_mem_cmd_type;
  typedef struct packed {
    logic                    cmd_full;
    logic                    wr_full;
    logic                    rd_empty;
    logic [`DBVF_DATA_W-1:0] rd_data;
  } dbvf_mem_stat_type;
  typedef enum logic [2:0] {
    st_idle    = 3'b000,
    st_wr_data = 3'b001,
    st_wr_cmd  = 3'b010,
    st_rd_cmd  = 3'b011,
    st_rd_wait = 3'b100,
    st_rd_pop  = 3'b101
  } dbvf_seq_type;
  typedef enum logic [2:0] {
    sel_none   = 3'b000,
    sel_len    = 3'b001,
    sel_start  = 3'b010,
    sel_end    = 3'b011,
    sel_status = 3'b100
  } dbvf_sel_type;
  typedef struct packed {
    logic [`DBVF_PTR_W-1:0] wptr;
    logic [`DBVF_PTR_W-1:0] rptr;
    logic [`DBVF_LVL_W-1:0] level;
  } dbvf_buf_state_type;
  typedef struct packed {
    dbvf_stream_type            out;
    logic [`DBVF_PKT_CNT_W-1:0] cnt;
  } dbvf_frm_state_type;
  typedef struct packed {
    dbvf_axil_out_type        axo;
    logic [31:0]              pkt_len;
    logic [31:0]              start_addr;
    logic [31:0]              end_addr;
    logic [31:0]              wptr;
    logic [31:0]              rptr;
    logic [31:0]              level;
    dbvf_seq_type             seq;
    logic                     turn;
    dbvf_mem_cmd_type         mem;
    logic                     h2c_ready;
    logic [`DBVF_SPACE_W-1:0] wr_space;
    logic [`DBVF_SPACE_W-1:0] rd_space;
    logic                     empty;
  } dbvf_top_state_type;
endpackage

// File: rtl/dbvf_buffer.sv
// 512 x 32 single-clock buffer with show-ahead read data.
// Assumes callers never push when full nor pop when empty.
`timescale 1ns/1ns
`include "dbvf_cfg.svh"
module dbvf_buffer (
  // Clock and reset
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // Fill side
  input  wire logic                    push,
  input  wire logic [`DBVF_DATA_W-1:0] push_data,
  // Drain side
  input  wire logic                    pop,
  output logic      [`DBVF_DATA_W-1:0] pop_data,
  output logic      [`DBVF_LVL_W-1:0]  level,
  output logic                         empty
);
  import dbvf_pkg::*;
  dbvf_buf_state_type      q;
  dbvf_buf_state_type      d;
  logic [`DBVF_DATA_W-1:0] store [0:`DBVF_DEPTH-1];
  logic                    do_push;
  logic                    do_pop;

  assign empty    = (q.level == '0);
  assign level    = q.level;
  assign pop_data = store[q.rptr];
  assign do_push  = push && (q.level != `DBVF_FULL_LVL);
  assign do_pop   = pop && !empty;

  always_comb begin
    d = q;
    if (do_push) begin
      d.wptr = q.wptr + `DBVF_PTR_W'(1);
    end
    if (do_pop) begin
      d.rptr = q.rptr + `DBVF_PTR_W'(1);
    end
    d.level = q.level + `DBVF_LVL_W'(do_push) - `DBVF_LVL_W'(do_pop);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  always_ff @(posedge aclk) begin
    if (do_push) begin
      store[q.wptr] <= push_data;
    end
  end
endmodule

// File: rtl/dbvf_framer.sv
// Cuts the returned word stream into fixed-size framed packets.
// Assumes the packet length is in bytes; zero or below one word means one word.
`timescale 1ns/1ns
`include "dbvf_cfg.svh"
module dbvf_framer (
  // Clock and reset
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // Buffer drain side
  input  wire logic [`DBVF_DATA_W-1:0] buf_data,
  input  wire logic                    buf_empty,
  output logic                         buf_pop,
  // Packet size
  input  wire logic [31:0]             pkt_len,
  // Card-to-host stream
  output dbvf_pkg::dbvf_stream_type    c2h,
  input  wire logic                    c2h_ready
);
  import dbvf_pkg::*;
  dbvf_frm_state_type         q;
  dbvf_frm_state_type         d;
  logic [`DBVF_PKT_CNT_W-1:0] words;
  logic [`DBVF_PKT_CNT_W-1:0] last;

  assign words = pkt_len[`DBVF_PKT_CNT_W+1:2];
  assign last  = (words == '0) ? '0 : words - `DBVF_PKT_CNT_W'(1);
  assign c2h   = q.out;

  always_comb begin
    d       = q;
    buf_pop = 1'b0;
    if (!q.out.valid || c2h_ready) begin
      d.out.valid = 1'b0;
      if (!buf_empty) begin
        buf_pop     = 1'b1; // (R09)
        d.out.data  = buf_data;
        d.out.sop   = (q.cnt == '0); // (R16)
        d.out.eop   = (q.cnt >= last); // (R04)
        d.out.valid = 1'b1;
        d.cnt       = (q.cnt >= last) ? '0 : q.cnt + `DBVF_PKT_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule

// File: rtl/dbvf_top.sv
// Memory-backed FIFO: host-to-card words go to external memory inside a
// programmable region and come back as fixed-size card-to-host packets.
// Assumes the memory controller user port and the streams share aclk.
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ns
`include "dbvf_cfg.svh"

// How it works
// (R01) Addresses generated inside; user supplies none
// (R02) Source frames are whole multiples of four bytes
// (R03) Data returns unchanged and in order
// (R04) Returned packets have the programmed fixed length
// (R05) Only the start-to-end region is used
// (R06) Pointer reaching end address wraps to start
// (R07) Writer marks each valid word with enable
// (R08) Write buffer free space shown on nine bits
// (R09) Read enable yields a word fetched from memory
// (R10) Readable word count shown on nine bits
// (R11) Empty flag whenever nothing is readable
// (R12) Input and output buffers, 512 x 32
// (R13) One 32-bit memory controller user port
// (R14) Host-to-card payload pushed into write buffer
// (R15) Command sequencer drives controller command interface
// (R16) Each packet framed start to end
// (R17) Single clock; reset restores initial state
// (R18) Everything runs in one clock domain
// (R19) No write when full, no read when empty
// (R20) Writes stop before overtaking unread data
// (R21) Reads only cover words already written
module dbvf_top (
  // Clock and reset
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  // Register bus
  input  wire dbvf_pkg::dbvf_axil_in_type axil_req,
  output      dbvf_pkg::dbvf_axil_out_type axil_rsp,
  // Host-to-card stream
  input  wire dbvf_pkg::dbvf_stream_type h2c,
  output logic                          h2c_ready,
  // Card-to-host stream
  output      dbvf_pkg::dbvf_stream_type c2h,
  input  wire logic                     c2h_ready,
  // Memory controller user port
  output      dbvf_pkg::dbvf_mem_cmd_type mem_req,
  input  wire dbvf_pkg::dbvf_mem_stat_type mem_stat,
  // FIFO status
  output logic [`DBVF_SPACE_W-1:0]      wr_space,
  output logic [`DBVF_SPACE_W-1:0]      rd_space,
  output logic                          empty
);
  import dbvf_pkg::*;

  dbvf_top_state_type      q;
  dbvf_top_state_type      d;
  logic                    in_push;
  logic                    in_pop;
  logic [`DBVF_DATA_W-1:0] in_data;
  logic [`DBVF_LVL_W-1:0]  in_level;
  logic                    in_empty;
  logic                    out_push;
  logic                    out_pop;
  logic [`DBVF_DATA_W-1:0] out_data;
  logic [`DBVF_LVL_W-1:0]  out_level;
  logic                    out_empty;
  dbvf_sel_type            wr_sel;
  dbvf_sel_type            rd_sel;
  logic [31:0]             capacity;
  logic                    wr_ok;
  logic                    rd_ok;
  logic                    aw_go;
  logic                    ar_go;
  logic [31:0]             wr_val;
  logic [31:0]             rd_val;

  function automatic dbvf_sel_type reg_decode(input logic [`DBVF_ADDR_W-1:0] addr);
    dbvf_sel_type sel;
    sel = sel_none;
    unique case (addr)
      `DBVF_OFF_PKT_LEN: sel = sel_len;
      `DBVF_OFF_START:   sel = sel_start;
      `DBVF_OFF_END:     sel = sel_end;
      `DBVF_OFF_STATUS:  sel = sel_status;
      default:           sel = sel_none;
    endcase
    return sel;
  endfunction

  function automatic logic [31:0] apply_strobe(input logic [31:0] old,
                                               input logic [31:0] neu,
                                               input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = neu[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Next word address inside the region
  function automatic logic [31:0] ptr_next(input logic [31:0] ptr,
                                           input logic [31:0] first,
                                           input logic [31:0] last);
    logic [31:0] nxt;
    nxt = ptr + `DBVF_WORD_BYTES;
    if (nxt >= last) begin
      nxt = first; // (R06)
    end
    return nxt;
  endfunction

  // Level clipped to the nine-bit status width
  function automatic logic [`DBVF_SPACE_W-1:0] sat_space(input logic [`DBVF_LVL_W-1:0] lvl);
    logic [`DBVF_SPACE_W-1:0] res;
    res = lvl[`DBVF_LVL_W-1] ? `DBVF_SPACE_MAX : lvl[`DBVF_SPACE_W-1:0];
    return res;
  endfunction

  // Write-side and read-side buffers
  dbvf_buffer u_in_buf (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .push      (in_push),
    .push_data (h2c.data),
    .pop       (in_pop),
    .pop_data  (in_data),
    .level     (in_level),
    .empty     (in_empty)
  ); // (R12)

  dbvf_buffer u_out_buf (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .push      (out_push),
    .push_data (mem_stat.rd_data),
    .pop       (out_pop),
    .pop_data  (out_data),
    .level     (out_level),
    .empty     (out_empty)
  ); // (R12)

  dbvf_framer u_framer (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .buf_data  (out_data),
    .buf_empty (out_empty),
    .buf_pop   (out_pop),
    .pkt_len   (q.pkt_len),
    .c2h       (c2h),
    .c2h_ready (c2h_ready)
  ); // (R16)

  // Payload only; frame markers are not kept
  assign in_push   = h2c.valid && q.h2c_ready; // (R14) (R07) (R02)
  assign wr_sel    = reg_decode(axil_req.awaddr);
  assign rd_sel    = reg_decode(axil_req.araddr);
  assign capacity  = (q.end_addr - q.start_addr) >> 2; // (R05)
  assign wr_ok     = !in_empty && (q.level < capacity); // (R20)
  assign rd_ok     = (q.level != '0) && (out_level < `DBVF_ROOM_LVL); // (R21)
  assign aw_go     = axil_req.awvalid && axil_req.wvalid && !q.axo.bvalid && !q.axo.awready;
  assign ar_go     = axil_req.arvalid && !q.axo.rvalid && !q.axo.arready;

  always_comb begin
    wr_val = '0;
    unique case (wr_sel)
      sel_len:   wr_val = apply_strobe(q.pkt_len, axil_req.wdata, axil_req.wstrb);
      sel_start: wr_val = apply_strobe(q.start_addr, axil_req.wdata, axil_req.wstrb);
      sel_end:   wr_val = apply_strobe(q.end_addr, axil_req.wdata, axil_req.wstrb);
      sel_status, sel_none: wr_val = '0;
    endcase
  end

  always_comb begin
    rd_val = '0;
    unique case (rd_sel)
      sel_len:   rd_val = q.pkt_len;
      sel_start: rd_val = q.start_addr;
      sel_end:   rd_val = q.end_addr;
      sel_status: begin
        rd_val[`DBVF_STAT_WR_LSB +: `DBVF_SPACE_W] = q.wr_space;
        rd_val[`DBVF_STAT_RD_LSB +: `DBVF_SPACE_W] = q.rd_space;
        rd_val[`DBVF_STAT_EMPTY_BIT]               = q.empty;
      end
      sel_none:  rd_val = '0;
    endcase
  end

  always_comb begin
    d        = q;
    in_pop   = 1'b0;
    out_push = 1'b0;

    // Register bus write: address and data taken together
    d.axo.awready = aw_go;
    d.axo.wready  = aw_go;
    if (q.axo.bvalid && axil_req.bready) begin
      d.axo.bvalid = 1'b0;
    end
    if (q.axo.awready) begin
      d.axo.bvalid = 1'b1;
      d.axo.bresp  = (wr_sel == sel_none) ? `DBVF_RESP_SLVERR : `DBVF_RESP_OKAY;
      unique case (wr_sel)
        sel_len:   d.pkt_len    = wr_val; // (R04)
        sel_start: d.start_addr = wr_val; // (R05)
        sel_end:   d.end_addr   = wr_val; // (R05)
        sel_status, sel_none: d.axo.bresp = d.axo.bresp;
      endcase
      // New region restarts the stored stream, except a wptr, rptr or level that the sequencer moves in the same cycle
      if ((wr_sel == sel_start) || (wr_sel == sel_end)) begin
        d.wptr  = d.start_addr;
        d.rptr  = d.start_addr;
        d.level = '0;
      end
    end

    // Register bus read
    d.axo.arready = ar_go;
    if (q.axo.rvalid && axil_req.rready) begin
      d.axo.rvalid = 1'b0;
    end
    if (q.axo.arready) begin
      d.axo.rvalid = 1'b1;
      d.axo.rdata  = rd_val;
      d.axo.rresp  = (rd_sel == sel_none) ? `DBVF_RESP_SLVERR : `DBVF_RESP_OKAY;
    end

    // Command sequencer, one word per command
    unique case (q.seq)
      st_idle: begin
        if (rd_ok && (!wr_ok || q.turn)) begin
          d.mem.cmd_en    = 1'b1; // (R15)
          d.mem.cmd_instr = `DBVF_CMD_READ;
          d.mem.cmd_addr  = q.rptr[`DBVF_MEM_ADDR_W-1:0]; // (R01)
          d.seq           = st_rd_cmd;
        end else if (wr_ok) begin
          in_pop          = 1'b1;
          d.mem.wr_en     = 1'b1; // (R03)
          d.mem.wr_data   = in_data;
          d.seq           = st_wr_data;
        end
      end
      st_wr_data: begin
        if (!mem_stat.wr_full) begin
          d.mem.wr_en     = 1'b0;
          d.mem.cmd_en    = 1'b1; // (R15)
          d.mem.cmd_instr = `DBVF_CMD_WRITE;
          d.mem.cmd_addr  = q.wptr[`DBVF_MEM_ADDR_W-1:0]; // (R01)
          d.seq           = st_wr_cmd;
        end
      end
      st_wr_cmd: begin
        if (!mem_stat.cmd_full) begin
          d.mem.cmd_en = 1'b0;
          d.wptr       = ptr_next(q.wptr, q.start_addr, q.end_addr); // (R06)
          d.level      = q.level + 32'h0000_0001; // (R21)
          d.turn       = 1'b1;
          d.seq        = st_idle;
        end
      end
      st_rd_cmd: begin
        if (!mem_stat.cmd_full) begin
          d.mem.cmd_en = 1'b0;
          d.rptr       = ptr_next(q.rptr, q.start_addr, q.end_addr); // (R06)
          d.seq        = st_rd_wait;
        end
      end
      st_rd_wait: begin
        if (!mem_stat.rd_empty) begin
          d.mem.rd_en = 1'b1;
          d.seq       = st_rd_pop;
        end
      end
      st_rd_pop: begin
        out_push    = 1'b1; // (R03)
        d.mem.rd_en = 1'b0;
        d.level     = q.level - 32'h0000_0001; // (R20)
        d.turn      = 1'b0;
        d.seq       = st_idle;
      end
      default: begin
        d.seq = st_idle;
      end
    endcase

    // Margin of two covers the registered ready
    d.h2c_ready = (in_level < `DBVF_ROOM_LVL); // (R19)
    d.wr_space  = sat_space(`DBVF_FULL_LVL - in_level); // (R08)
    d.rd_space  = sat_space(out_level); // (R10)
    d.empty     = ((out_level + `DBVF_LVL_W'(out_push) - `DBVF_LVL_W'(out_pop)) == '0); // (R11)
  end

  always_ff @(posedge aclk) begin // (R18)
    if (!aresetn) begin // (R17)
      q               <= '0;
      q.pkt_len       <= `DBVF_RST_PKT_LEN;
      q.start_addr    <= `DBVF_RST_START;
      q.end_addr      <= `DBVF_RST_END;
      q.wptr          <= `DBVF_RST_START;
      q.rptr          <= `DBVF_RST_START;
      q.seq           <= st_idle;
      q.mem.cmd_bl    <= `DBVF_BURST_ONE; // (R13)
      q.mem.wr_mask   <= `DBVF_MASK_NONE;
      q.empty         <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign axil_rsp  = q.axo;
  assign h2c_ready = q.h2c_ready;
  assign mem_req   = q.mem;
  assign wr_space  = q.wr_space;
  assign rd_space  = q.rd_space;
  assign empty     = q.empty;
endmodule

// File: tb/dbvf_checker.sv
// Concurrent checks on the memory-backed FIFO top ports.
// Assumes binding to dbvf_top; single clock aclk, synchronous aresetn.
`timescale 1ns/1ns
`include "dbvf_cfg.svh"
module dbvf_checker (
  // Clock and reset
  input wire logic                         aclk,
  input wire logic                         aresetn,
  // Register bus
  input wire dbvf_pkg::dbvf_axil_in_type   axil_req,
  input wire dbvf_pkg::dbvf_axil_out_type  axil_rsp,
  // Streams
  input wire logic                         h2c_ready,
  input wire dbvf_pkg::dbvf_stream_type    c2h,
  input wire logic                         c2h_ready,
  // Memory port and status
  input wire dbvf_pkg::dbvf_mem_cmd_type   mem_req,
  input wire dbvf_pkg::dbvf_mem_stat_type  mem_stat,
  input wire logic                         empty
);
  import dbvf_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_aw_both: assert property (
    axil_rsp.awready |-> $past(axil_req.awvalid && axil_req.wvalid && !axil_rsp.bvalid))
    else $error("write taken without both channels");
  a_write_resp: assert property (
    axil_rsp.awready |=> axil_rsp.bvalid && !axil_rsp.awready)
    else $error("write response late or ready too long");
  a_read_resp: assert property (
    axil_rsp.arready |=> axil_rsp.rvalid && !axil_rsp.arready)
    else $error("read response late or ready too long");
  a_cmd_shape: assert property (
    mem_req.cmd_en |-> mem_req.cmd_addr[1:0] == 2'h0 && mem_req.cmd_bl == `DBVF_BURST_ONE
      && mem_req.cmd_instr inside {`DBVF_CMD_WRITE, `DBVF_CMD_READ})
    else $error("bad command shape");
  a_cmd_hold: assert property (
    mem_req.cmd_en && mem_stat.cmd_full |=> mem_req.cmd_en && $stable(mem_req.cmd_addr)
      && $stable(mem_req.cmd_instr))
    else $error("command dropped while port full");
  a_wdata_hold: assert property (
    mem_req.wr_en && mem_stat.wr_full |=> mem_req.wr_en && $stable(mem_req.wr_data))
    else $error("write data dropped while port full");
  a_wr_then_cmd: assert property (
    mem_req.wr_en && !mem_stat.wr_full |=> mem_req.cmd_en
      && mem_req.cmd_instr == `DBVF_CMD_WRITE)
    else $error("write command does not follow data");
  a_fetch_pulse: assert property (
    mem_req.rd_en |-> $past(!mem_stat.rd_empty) ##1 !mem_req.rd_en)
    else $error("read pop without data or too long");
  a_c2h_hold: assert property (
    c2h.valid && !c2h_ready |=> c2h.valid && $stable(c2h))
    else $error("stream word changed before taken");
  a_sop_after_eop: assert property (
    c2h.valid && c2h_ready && c2h.eop |=> !c2h.valid || c2h.sop)
    else $error("packet start missing after end");
  a_reset_quiet: assert property (
    $rose(aresetn) |-> !c2h.valid && !mem_req.cmd_en && !h2c_ready && empty)
    else $error("outputs not at reset state");
endmodule

bind dbvf_top dbvf_checker chk (.aclk(aclk), .aresetn(aresetn), .axil_req(axil_req),
  .axil_rsp(axil_rsp), .h2c_ready(h2c_ready), .c2h(c2h), .c2h_ready(c2h_ready),
  .mem_req(mem_req), .mem_stat(mem_stat), .empty(empty));

// File: tb/dbvf_mem_model.sv
// Behavioural memory controller user port, one word per command.
// Assumes the shared clock; slow stretches every handshake of the port.
`timescale 1ns/1ns
`include "dbvf_cfg.svh"
module dbvf_mem_model (
  // Clock and reset
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  // User port
  input  wire dbvf_pkg::dbvf_mem_cmd_type  mem_req,
  output      dbvf_pkg::dbvf_mem_stat_type mem_stat,
  // Pacing
  input  wire logic                        slow
);
  import dbvf_pkg::*;
  logic [31:0] store [logic [29:0]];
  logic [31:0] wq    [$];
  logic [31:0] rq    [$];
  logic [2:0]  tick;
  always @(posedge aclk) begin
    if (!aresetn) begin
      wq.delete();
      rq.delete();
      tick <= 3'h0;
      mem_stat <= '{1'h0, 1'h0, 1'h1, 32'h0000_0000};
    end else begin
      if (mem_req.wr_en && !mem_stat.wr_full)
        wq.push_back(mem_req.wr_data);
      if (mem_req.rd_en)
        void'(rq.pop_front());
      if (mem_req.cmd_en && !mem_stat.cmd_full) begin
        if (mem_req.cmd_instr == `DBVF_CMD_WRITE)
          store[mem_req.cmd_addr] = wq.pop_front();
        else
          rq.push_back(store[mem_req.cmd_addr]);
      end
      tick <= tick + 3'h1;
      mem_stat.cmd_full <= slow && tick[0];
      mem_stat.wr_full  <= slow && tick[1];
      // Word once shown stays shown until consumed
      mem_stat.rd_empty <= (rq.size() == 0) || (slow && tick[2] && mem_stat.rd_empty);
      mem_stat.rd_data  <= (rq.size() != 0) ? rq[0] : ~mem_stat.rd_data;
    end
  end
endmodule

// File: tb/dbvf_top_test.sv
// Self-checking bench for the memory-backed FIFO top.
// Assumes the checker is bound and the memory model stands on the user port.
`timescale 1ns/1ns
`include "dbvf_cfg.svh"
module dbvf_top_test;
  import dbvf_pkg::*;
  logic              aclk;
  logic              aresetn   = 1'h0;
  logic              slow      = 1'h1;
  logic              sink_on   = 1'h0;
  logic              c2h_ready = 1'h0;
  dbvf_axil_in_type  axil_req  = '0;
  dbvf_stream_type   h2c       = '0;
  dbvf_axil_out_type axil_rsp;
  dbvf_stream_type   c2h;
  dbvf_mem_cmd_type  mem_req;
  dbvf_mem_stat_type mem_stat;
  logic              h2c_ready;
  logic              empty;
  logic [8:0]        wr_space;
  logic [8:0]        rd_space;
  logic [31:0]       st;
  logic [31:0]       en;
  logic [31:0]       wexp;
  logic [31:0]       rexp;
  logic [15:0]       offs [3] = '{`DBVF_OFF_PKT_LEN, `DBVF_OFF_START, `DBVF_OFF_END};
  logic [31:0]       cfg  [3] = '{32'h0000_0010, 32'h0000_0100, 32'h0000_0140};
  int                err_count, comparisons, cyc, nrx, ntx, fill;

  dbvf_top uut (.aclk(aclk), .aresetn(aresetn), .axil_req(axil_req), .axil_rsp(axil_rsp),
    .h2c(h2c), .h2c_ready(h2c_ready), .c2h(c2h), .c2h_ready(c2h_ready), .mem_req(mem_req),
    .mem_stat(mem_stat), .wr_space(wr_space), .rd_space(rd_space), .empty(empty));
  dbvf_mem_model mem (.aclk(aclk), .aresetn(aresetn), .mem_req(mem_req),
    .mem_stat(mem_stat), .slow(slow));

  initial begin
    aclk = 1'h0;
    forever #20 aclk = ~aclk;
  end

  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic end_of_test;
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    axil_req.awaddr  <= a;
    axil_req.wdata   <= d;
    axil_req.wstrb   <= 4'hF;
    axil_req.awvalid <= 1'h1;
    axil_req.wvalid  <= 1'h1;
    axil_req.bready  <= 1'h1;
    forever begin
      @(posedge aclk);
      if (axil_rsp.awready) axil_req.awvalid <= 1'h0;
      if (axil_rsp.wready) axil_req.wvalid <= 1'h0;
      if (axil_rsp.bvalid) begin
        cmp("bresp", {30'h0, er}, {30'h0, axil_rsp.bresp});
        axil_req.bready <= 1'h0;
        break;
      end
    end
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    axil_req.araddr  <= a;
    axil_req.arvalid <= 1'h1;
    axil_req.rready  <= 1'h1;
    forever begin
      @(posedge aclk);
      if (axil_rsp.arready) axil_req.arvalid <= 1'h0;
      if (axil_rsp.rvalid) begin
        cmp("rdata", e, axil_rsp.rdata);
        cmp("rresp", {30'h0, er}, {30'h0, axil_rsp.rresp});
        axil_req.rready <= 1'h0;
        break;
      end
    end
  endtask

  task automatic defaults;
    rd(`DBVF_OFF_PKT_LEN, `DBVF_RST_PKT_LEN, `DBVF_RESP_OKAY);
    rd(`DBVF_OFF_START, `DBVF_RST_START, `DBVF_RESP_OKAY);
    rd(`DBVF_OFF_END, `DBVF_RST_END, `DBVF_RESP_OKAY);
    rd(`DBVF_OFF_STATUS, 32'h0004_01FF, `DBVF_RESP_OKAY);
    cmp("empty", 32'h1, {31'h0, empty});
    cmp("wr_space", 32'h1FF, {23'h0, wr_space});
    cmp("rd_space", 32'h0, {23'h0, rd_space});
  endtask

  task automatic push(input int n);
    @(posedge aclk);
    for (int i = 0; i < n; i++) begin
      h2c <= {32'hA5A5_0000 + ntx, 3'h1};
      ntx++;
      do @(posedge aclk); while (!h2c_ready);
    end
    h2c.valid <= 1'h0;
  endtask

  function automatic logic [31:0] nxt(input logic [31:0] a);
    return (a + `DBVF_WORD_BYTES >= en) ? st : a + `DBVF_WORD_BYTES;
  endfunction

  // Memory command address and fill tracking
  always @(posedge aclk) begin
    if (aresetn && mem_req.cmd_en && !mem_stat.cmd_full) begin
      if (mem_req.cmd_instr == `DBVF_CMD_WRITE) begin
        cmp("wr_addr", wexp, {2'h0, mem_req.cmd_addr});
        wexp = nxt(wexp);
        fill++;
        cmp("fill_ok", 32'h1, {31'h0, fill <= (en - st) / 4});
      end else begin
        cmp("rd_addr", rexp, {2'h0, mem_req.cmd_addr});
        rexp = nxt(rexp);
        fill--;
      end
    end
  end

  // Card-to-host sink with back-pressure
  always @(posedge aclk) begin
    c2h_ready <= sink_on && (cyc % 3 != 0);
    if (aresetn && c2h.valid && c2h_ready) begin
      cmp("c2h_data", 32'hA5A5_0000 + nrx, c2h.data);
      cmp("c2h_sop", {31'h0, nrx % 4 == 0}, {31'h0, c2h.sop});
      cmp("c2h_eop", {31'h0, nrx % 4 == 3}, {31'h0, c2h.eop});
      nrx++;
    end
  end

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      end_of_test();
    end
  end

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    wr(`DBVF_OFF_STATUS, 32'h0000_0000, `DBVF_RESP_OKAY);
    defaults();
    wr(16'h9000, 32'hDEAD_BEEF, `DBVF_RESP_SLVERR);
    rd(16'h9000, 32'h0000_0000, `DBVF_RESP_SLVERR);
    for (int i = 0; i < 3; i++) wr(offs[i], cfg[i], `DBVF_RESP_OKAY);
    for (int i = 0; i < 3; i++) rd(offs[i], cfg[i], `DBVF_RESP_OKAY);
    st = cfg[1];
    en = cfg[2];
    wexp = st;
    rexp = st;
    push(40);
    repeat (1000) @(posedge aclk);
    cmp("empty", 32'h0, {31'h0, empty});
    cmp("rd_space", 32'h27, {23'h0, rd_space});
    sink_on <= 1'h1;
    while (nrx < 40) @(posedge aclk);
    repeat (20) @(posedge aclk);
    cmp("empty", 32'h1, {31'h0, empty});
    cmp("rd_space", 32'h0, {23'h0, rd_space});
    cmp("wr_space", 32'h1FF, {23'h0, wr_space});
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    defaults();
    end_of_test();
  end
endmodule
